// *** rcc_top.sv ***
// Command handler for receiver configuration query/set and config save.
// Assumes rx bytes come from logic on clk_i; store port is a req/done handshake.
//
// Contract
// RQ1 - A packet starts with 0x10, then 0x91, then a subpacket byte; 0x01 is receiver config.
// RQ2 - Bytes 3 and 4 hold a 16-bit length of mode, payload and checksum only.
// RQ3 - A packet ends with a checksum byte then delimiters 0x10 and 0x03.
// RQ4 - The config response carries mode 2 in byte 5, fields in 6 to 31, checksum in 32.
// RQ5 - Bytes 6 to 9 are a band enable mask; reserved or unsupported bits enable nothing.
// RQ6 - Mask bits 0,2,4,5,8,12,14 select GPS L1, GPS L5, G1, G2, SBAS, B1 and B2a.
// RQ7 - Bytes 10 to 13 are a float elevation limit 0 to 90, used only in overdetermined mode.
// RQ8 - Bytes 14 to 17 are a float signal limit 0 to 37, used in overdetermined mode.
// RQ9 - Bytes 18 to 21 are a float dilution limit 0 to 10.
// RQ10 - Subpacket 0x02 mode 1 with byte 6 equal to 1 saves the user config.
// RQ11 - A save is answered with mode 2 and status 0 on failure, 1 on success.
// RQ12 - Packets with bad checksum, length or delimiters are dropped without answer.
// RQ13 - A field of all ones is absent and leaves the stored value as it was.
//
// Added by the designer: the address map and register access over AXI4-Lite.
module rcc_top
    import rcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Command byte stream in
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    output logic             rx_ready_o,
    // Response byte stream out
    output logic             tx_valid_o,
    output logic [7:0]       tx_data_o,
    input  wire logic        tx_ready_i,
    // Nonvolatile store handshake
    output logic             store_req_o,
    input  wire logic        store_done_i,
    input  wire logic        store_ok_i,
    // Fix engine
    input  wire logic        overdet_mode_i,
    output logic [31:0]      band_mask_o,
    output logic [31:0]      elev_limit_o,
    output logic [31:0]      signal_limit_o,
    output logic [31:0]      dilution_limit_o,
    output logic [31:0]      cable_delay_o,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import rcc_pkg::*;

    typedef enum logic [7:0] {
        P_IDLE = 8'h01, P_PID  = 8'h02, P_SUB  = 8'h04, P_LENH = 8'h08,
        P_LENL = 8'h10, P_BODY = 8'h20, P_END1 = 8'h40, P_END2 = 8'h80
    } rcc_prs_t;
    typedef enum logic [2:0] {
        X_IDLE = 3'b001, X_STORE = 3'b010, X_SEND = 3'b100
    } rcc_exe_t;

    rcc_prs_t     prs_q;
    rcc_exe_t     exe_q;
    logic [7:0]   body_q [0:BODY_MAX-1];
    logic [7:0]   sub_q;
    logic [15:0]  len_q;
    logic [4:0]   cnt_q;
    logic [7:0]   xor_q;
    logic         good_q;
    logic         apply_q;
    logic [31:0]  mask_q, elev_q, sig_q, dil_q, cable_q, resv_q;
    logic [7:0]   aj_q, fix_q;
    logic         save_ok_q;
    logic         en_q;
    logic [15:0]  good_cnt_q, drop_cnt_q;
    logic [5:0]   tidx_q;
    logic [7:0]   tcks_q;
    logic         tsub2_q;

    // Byte handshake and running check
    wire          rx_take  = rx_valid_i && rx_ready_o;
    wire [7:0]    xor_nx   = xor_q ^ rx_data_i;
    wire          body_end = (prs_q == P_BODY) && ({11'h0, cnt_q} == len_q - 16'h0001);
    wire [15:0]   len_nx   = {len_q[7:0], rx_data_i};
    wire          len_bad  = (len_nx == 16'h0000) || (len_nx > BODY_MAX_LEN);

    function automatic logic [31:0] body32(input int b);
        return {body_q[b], body_q[b+1], body_q[b+2], body_q[b+3]};
    endfunction

    // Decoded set request
    wire [7:0]    mode_w   = body_q[B_MODE];
    wire          is_cfg   = sub_q == SUB_RXCFG;
    wire          is_sto   = sub_q == SUB_STORE;
    wire          cfg_set  = is_cfg && (mode_w == MODE_SET) && (len_q == BODY_MAX_LEN);
    wire          do_save  = is_sto && (mode_w == MODE_SET) && (body_q[B_SAVE] == SAVE_DO);
    wire [31:0]   in_mask  = body32(B_MASK);
    wire [31:0]   in_elev  = body32(B_ELEV);
    wire [31:0]   in_sig   = body32(B_SIG);
    wire [31:0]   in_dil   = body32(B_DIL);
    wire [31:0]   in_cable = body32(B_CABLE);
    wire [31:0]   in_resv  = body32(B_RESV);
    // Floats compare as integers only when the sign is clear
    wire          ok_elev  = !in_elev[31] && (in_elev <= ELEV_MAX); // RQ7
    wire          ok_sig   = !in_sig[31] && (in_sig <= SIG_MAX); // RQ8
    wire          ok_dil   = !in_dil[31] && (in_dil <= DIL_MAX); // RQ9
    wire          apply    = apply_q && cfg_set;
    wire          want_rsp = good_q && (is_cfg ||
                             (is_sto && (mode_w == MODE_SET)));

    // Packet parser
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            prs_q   <= P_IDLE;
            sub_q   <= 8'h00;
            len_q   <= 16'h0000;
            cnt_q   <= 5'h00;
            xor_q   <= 8'h00;
            good_q  <= 1'b0;
            apply_q <= 1'b0;
        end else begin
            good_q  <= 1'b0;
            apply_q <= 1'b0;
            if (rx_take) begin
                case (prs_q)
                    P_IDLE: if (rx_data_i == FRM_START) prs_q <= P_PID; // RQ1
                    P_PID: begin
                        prs_q <= (rx_data_i == FRM_PID) ? P_SUB : P_IDLE; // RQ1
                        xor_q <= rx_data_i;
                    end
                    P_SUB: begin
                        sub_q <= rx_data_i;
                        xor_q <= xor_nx;
                        prs_q <= (rx_data_i == SUB_RXCFG || rx_data_i == SUB_STORE)
                                 ? P_LENH : P_IDLE; // RQ1
                    end
                    P_LENH: begin
                        len_q <= {8'h00, rx_data_i}; // RQ2
                        xor_q <= xor_nx;
                        prs_q <= P_LENL;
                    end
                    P_LENL: begin
                        len_q <= len_nx; // RQ2
                        xor_q <= xor_nx;
                        cnt_q <= 5'h00;
                        prs_q <= len_bad ? P_IDLE : P_BODY; // RQ12
                    end
                    P_BODY: begin
                        body_q[cnt_q] <= rx_data_i;
                        xor_q <= xor_nx;
                        cnt_q <= cnt_q + 5'h01;
                        if (body_end) prs_q <= P_END1; // RQ3
                    end
                    P_END1: prs_q <= (rx_data_i == FRM_END1) ? P_END2 : P_IDLE; // RQ3
                    P_END2: begin
                        prs_q   <= P_IDLE;
                        // Checksum byte folds the xor to zero
                        good_q  <= (rx_data_i == FRM_END2) && (xor_q == 8'h00); // RQ12
                        apply_q <= (rx_data_i == FRM_END2) && (xor_q == 8'h00);
                    end
                    default: prs_q <= P_IDLE;
                endcase
            end
        end
    end

    // Counters of accepted and dropped packets
    wire drop_ev = rx_take && ((prs_q == P_END1 && rx_data_i != FRM_END1) ||
                   (prs_q == P_END2 && (rx_data_i != FRM_END2 || xor_q != 8'h00)) ||
                   (prs_q == P_LENL && len_bad));
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            good_cnt_q <= 16'h0000;
            drop_cnt_q <= 16'h0000;
        end else begin
            if (good_q) good_cnt_q <= good_cnt_q + 16'h0001;
            if (drop_ev) drop_cnt_q <= drop_cnt_q + 16'h0001;
        end
    end

    // Execution: store handshake then response
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            exe_q       <= X_IDLE;
            store_req_o <= 1'b0;
            save_ok_q   <= 1'b1;
            tsub2_q     <= 1'b0;
        end else begin
            case (exe_q)
                X_IDLE: if (want_rsp) begin
                    tsub2_q <= is_sto;
                    if (do_save) begin
                        exe_q       <= X_STORE;
                        store_req_o <= 1'b1; // RQ10
                    end else begin
                        exe_q <= X_SEND;
                    end
                end
                X_STORE: if (store_done_i) begin
                    store_req_o <= 1'b0;
                    save_ok_q   <= store_ok_i; // RQ11
                    exe_q       <= X_SEND;
                end
                X_SEND: if (tx_valid_o && tx_ready_i && tidx_q == 6'h00) exe_q <= X_IDLE;
                default: exe_q <= X_IDLE;
            endcase
        end
    end

    // Response byte selection
    wire [PAY_BITS-1:0] pay_cfg = {mask_q, elev_q, sig_q, dil_q, aj_q, fix_q, cable_q,
                                   resv_q}; // RQ4
    wire [PAY_BITS-1:0] pay_sto = {7'h00, save_ok_q, 32'h0000_0000, 168'h0}; // RQ11
    wire [PAY_BITS-1:0] pay_w   = tsub2_q ? pay_sto : pay_cfg;
    wire [5:0]    pay_n    = tsub2_q ? 6'(PAY_STORE) : 6'(PAY_RXCFG);
    wire [5:0]    t_cks    = T_PAY + pay_n;
    wire [5:0]    t_last   = t_cks + 6'h02;
    wire [5:0]    pk       = tidx_q - T_PAY;
    wire [7:0]    pay_byte = pay_w[PAY_BITS-1 - 8*pk -: 8];
    wire [7:0]    len_byte = 8'(pay_n) + 8'h02;
    wire [7:0]    sub_byte = tsub2_q ? SUB_STORE : SUB_RXCFG;
    wire [7:0]    t_byte   = (tidx_q == 6'h00) ? FRM_START :
                             (tidx_q == 6'h01) ? FRM_PID :
                             (tidx_q == 6'h02) ? sub_byte :
                             (tidx_q == 6'h03) ? 8'h00 :
                             (tidx_q == 6'h04) ? len_byte :
                             (tidx_q == 6'h05) ? MODE_RESP :
                             (tidx_q < t_cks)  ? pay_byte :
                             (tidx_q == t_cks) ? tcks_q :
                             (tidx_q == t_cks + 6'h01) ? FRM_END1 : FRM_END2;
    wire          tx_load  = (exe_q == X_SEND) && (!tx_valid_o || tx_ready_i);

    // Response transmitter; tx_data_o is always a registered byte
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o  <= 8'h00;
            tidx_q     <= 6'h00;
            tcks_q     <= 8'h00;
        end else if (tx_load && !(tx_valid_o && tidx_q == 6'h00)) begin
            tx_valid_o <= 1'b1;
            tx_data_o  <= t_byte; // RQ4
            if (tidx_q == 6'h01) tcks_q <= t_byte;
            else if (tidx_q > 6'h01 && tidx_q < t_cks) tcks_q <= tcks_q ^ t_byte;
            tidx_q <= (tidx_q == t_last) ? 6'h00 : tidx_q + 6'h01; // RQ3
        end else if (tx_valid_o && tx_ready_i) begin
            tx_valid_o <= 1'b0;
        end
    end

    // Input is held off while a packet is executed
    always_ff @(posedge clk_i) begin
        if (!rstn_i) rx_ready_o <= 1'b0;
        else         rx_ready_o <= en_q && (exe_q == X_IDLE) && !good_q;
    end

    // AXI4-Lite slave: one write and one read at a time
    wire          aw_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    wire          ar_go   = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire          wr      = s_axi_awready;
    wire [7:0]    wa      = s_axi_awaddr;
    wire [31:0]   wmask   = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire [31:0]   wmerge  = s_axi_wdata & wmask;
    wire          wa_ok   = (wa <= A_DROP) && (wa[1:0] == 2'b00) && (wa != A_STAT) &&
                            (wa != A_GOOD);
    wire [31:0]   stat_w  = {28'h0, overdet_mode_i, save_ok_q, store_req_o,
                             exe_q != X_IDLE};
    wire [7:0]    ra      = s_axi_araddr;
    wire [31:0]   rd_w    = (ra == A_CTRL)  ? {31'h0, en_q} :
                            (ra == A_STAT)  ? stat_w :
                            (ra == A_MASK)  ? mask_q :
                            (ra == A_ELEV)  ? elev_q :
                            (ra == A_SIG)   ? sig_q :
                            (ra == A_DIL)   ? dil_q :
                            (ra == A_MISC)  ? {16'h0, fix_q, aj_q} :
                            (ra == A_CABLE) ? cable_q :
                            (ra == A_RESV)  ? resv_q :
                            (ra == A_GOOD)  ? {16'h0, good_cnt_q} :
                            (ra == A_DROP)  ? {16'h0, drop_cnt_q} : 32'h0000_0000;
    wire          ra_ok   = (ra <= A_DROP) && (ra[1:0] == 2'b00);

    function automatic logic [31:0] wmix(input logic [31:0] old);
        return (old & ~wmask) | wmerge;
    endfunction

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= aw_go;
            s_axi_wready  <= aw_go;
            if (wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wa_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= ar_go;
            if (ar_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_w;
                s_axi_rresp  <= ra_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Configuration store; a bus write in the same cycle overrides a packet
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            en_q    <= 1'b1;
            mask_q  <= RST_MASK;
            elev_q  <= RST_ELEV;
            sig_q   <= RST_SIG;
            dil_q   <= RST_DIL;
            aj_q    <= RST_AJ;
            fix_q   <= RST_FIX;
            cable_q <= 32'h0000_0000;
            resv_q  <= 32'h0000_0000;
        end else begin
            if (apply) begin
                if (in_mask != WORD_ABSENT) mask_q <= in_mask & MASK_SUPP; // RQ13
                if (in_elev != WORD_ABSENT && ok_elev) elev_q <= in_elev; // RQ13
                if (in_sig != WORD_ABSENT && ok_sig) sig_q <= in_sig; // RQ13
                if (in_dil != WORD_ABSENT && ok_dil) dil_q <= in_dil; // RQ13
                if (body_q[B_AJ] != BYTE_ABSENT) aj_q <= body_q[B_AJ]; // RQ13
                if (body_q[B_FIX] != BYTE_ABSENT) fix_q <= body_q[B_FIX]; // RQ13
                if (in_cable != WORD_ABSENT) cable_q <= in_cable; // RQ13
                if (in_resv != WORD_ABSENT) resv_q <= in_resv;
            end
            if (wr) begin
                if (wa == A_CTRL && s_axi_wstrb[0]) en_q <= s_axi_wdata[0];
                if (wa == A_MASK)  mask_q  <= wmix(mask_q) & MASK_SUPP; // RQ5
                if (wa == A_ELEV)  elev_q  <= wmix(elev_q);
                if (wa == A_SIG)   sig_q   <= wmix(sig_q);
                if (wa == A_DIL)   dil_q   <= wmix(dil_q);
                if (wa == A_MISC && s_axi_wstrb[0]) aj_q  <= s_axi_wdata[7:0];
                if (wa == A_MISC && s_axi_wstrb[1]) fix_q <= s_axi_wdata[15:8];
                if (wa == A_CABLE) cable_q <= wmix(cable_q);
                if (wa == A_RESV)  resv_q  <= wmix(resv_q);
            end
        end
    end

    // Limits reach the fix engine; elevation and signal only in overdetermined mode
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            band_mask_o      <= RST_MASK;
            elev_limit_o     <= RST_ELEV;
            signal_limit_o   <= RST_SIG;
            dilution_limit_o <= RST_DIL;
            cable_delay_o    <= 32'h0000_0000;
        end else begin
            band_mask_o      <= mask_q & MASK_SUPP; // RQ6
            elev_limit_o     <= overdet_mode_i ? elev_q : RST_ELEV; // RQ7
            signal_limit_o   <= overdet_mode_i ? sig_q : RST_SIG; // RQ8
            dilution_limit_o <= dil_q; // RQ9
            cable_delay_o    <= cable_q;
        end
    end
endmodule

// *** rcc_pkg.sv ***
// Constants shared by the receiver configuration command handler.
// Assumes a byte stream on the core clock and an AXI4-Lite host.
package rcc_pkg;
    // Framing bytes
    localparam logic [7:0]  FRM_START    = 8'h10;
    localparam logic [7:0]  FRM_PID      = 8'h91;
    localparam logic [7:0]  FRM_END1     = 8'h10;
    localparam logic [7:0]  FRM_END2     = 8'h03;
    localparam logic [7:0]  SUB_RXCFG    = 8'h01;
    localparam logic [7:0]  SUB_STORE    = 8'h02;
    localparam logic [7:0]  MODE_QUERY   = 8'h00;
    localparam logic [7:0]  MODE_SET     = 8'h01;
    localparam logic [7:0]  MODE_RESP    = 8'h02;
    localparam logic [7:0]  SAVE_DO      = 8'h01;
    localparam logic [7:0]  BYTE_ABSENT  = 8'hff;
    localparam logic [31:0] WORD_ABSENT  = 32'hffff_ffff;
    // Body: mode, payload, checksum
    localparam int          BODY_MAX     = 28;
    localparam logic [15:0] BODY_MAX_LEN = 16'h001c;
    localparam int          PAY_RXCFG    = 26;
    localparam int          PAY_STORE    = 5;
    localparam int          PAY_BITS     = 208;
    // Body offsets (packet byte index minus 5)
    localparam int          B_MODE       = 0;
    localparam int          B_MASK       = 1;
    localparam int          B_ELEV       = 5;
    localparam int          B_SIG        = 9;
    localparam int          B_DIL        = 13;
    localparam int          B_AJ         = 17;
    localparam int          B_FIX        = 18;
    localparam int          B_CABLE      = 19;
    localparam int          B_RESV       = 23;
    localparam int          B_SAVE       = 1;
    // Response byte positions
    localparam logic [5:0]  T_PAY        = 6'h06;
    // Supported band bits: 0,2,4,5,8,12,14,16,17,21,23
    localparam logic [31:0] MASK_SUPP    = 32'h00a3_5135;
    // Single-precision upper limits
    localparam logic [31:0] ELEV_MAX     = 32'h42b4_0000;
    localparam logic [31:0] SIG_MAX      = 32'h4214_0000;
    localparam logic [31:0] DIL_MAX      = 32'h4120_0000;
    // Reset values
    localparam logic [31:0] RST_MASK     = 32'h0000_0035;
    localparam logic [31:0] RST_ELEV     = 32'h0000_0000;
    localparam logic [31:0] RST_SIG      = 32'h0000_0000;
    localparam logic [31:0] RST_DIL      = 32'h4120_0000;
    localparam logic [7:0]  RST_AJ       = 8'h01;
    localparam logic [7:0]  RST_FIX      = 8'h00;
    // Register byte offsets
    localparam logic [7:0]  A_CTRL       = 8'h00;
    localparam logic [7:0]  A_STAT       = 8'h04;
    localparam logic [7:0]  A_MASK       = 8'h08;
    localparam logic [7:0]  A_ELEV       = 8'h0c;
    localparam logic [7:0]  A_SIG        = 8'h10;
    localparam logic [7:0]  A_DIL        = 8'h14;
    localparam logic [7:0]  A_MISC       = 8'h18;
    localparam logic [7:0]  A_CABLE      = 8'h1c;
    localparam logic [7:0]  A_RESV       = 8'h20;
    localparam logic [7:0]  A_GOOD       = 8'h24;
    localparam logic [7:0]  A_DROP       = 8'h28;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage

// *** rcc_assertions.sv ***
// Port checker for the command handler.
// Assumes it is bound to rcc_top and sees only its ports.
module rcc_assertions
    import rcc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        tx_valid_o,
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_ready_i,
    input wire logic        store_req_o,
    input wire logic        store_done_i,
    input wire logic        overdet_mode_i,
    input wire logic [31:0] band_mask_o,
    input wire logic [31:0] elev_limit_o,
    input wire logic [31:0] signal_limit_o,
    input wire logic [31:0] dilution_limit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence first_taken;
        $rose(tx_valid_o) ##0 tx_ready_i;
    endsequence
    tx_hold_a: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("tx moved");
    first_byte_a: assert property (
        $rose(tx_valid_o) |-> tx_data_o == FRM_START) else $error("bad start byte");
    pid_next_a: assert property (
        first_taken |=> tx_valid_o && tx_data_o == FRM_PID) else $error("bad packet id");
    req_hold_a: assert property (
        store_req_o && !store_done_i |=> store_req_o) else $error("save request dropped");
    mask_supp_a: assert property (
        (band_mask_o & ~MASK_SUPP) == 32'h0000_0000) else $error("reserved band bit set");
    elev_mode_a: assert property (
        !overdet_mode_i |=> elev_limit_o == 32'h0000_0000) else $error("elev used off mode");
    sig_mode_a: assert property (
        !overdet_mode_i |=> signal_limit_o == 32'h0000_0000) else $error("signal used off mode");
    dil_range_a: assert property (
        dilution_limit_o <= DIL_MAX) else $error("dilution limit out of range");
endmodule

bind rcc_top rcc_assertions chk_u (.clk_i, .rstn_i, .tx_valid_o, .tx_data_o, .tx_ready_i,
    .store_req_o, .store_done_i, .overdet_mode_i, .band_mask_o, .elev_limit_o,
    .signal_limit_o, .dilution_limit_o);

// *** rcc_store_model.sv ***
// Nonvolatile store stand-in for the save handshake.
// Assumes one request at a time; result chosen by the bench.
module rcc_store_model (
    input  wire logic       clk_i,
    input  wire logic       store_req_i,
    input  wire logic       ok_sel_i,
    input  wire logic [3:0] delay_i,
    output logic            store_done_o = 1'h0,
    output logic            store_ok_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q = 4'h0;
    logic       fire;
    assign fire = store_req_i && !store_done_o && cnt_q == delay_i;
    always_ff @(posedge clk_i) begin
        cnt_q        <= store_req_i && !store_done_o ? cnt_q + 4'h1 : 4'h0;
        store_done_o <= fire;
        // Result line is junk outside the done pulse
        store_ok_o   <= fire ? ok_sel_i : !ok_sel_i;
    end
endmodule

// *** tb.sv ***
// Self-checking bench for the command handler.
// Assumes rcc_store_model answers the save handshake.
module tb;
    import rcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rstn_i = 0, rx_valid_i = 0, tx_ready_i = 1, overdet_mode_i = 0;
    logic        rx_ready_o, tx_valid_o, store_req_o, store_done_i, store_ok_i, ok_sel = 0;
    logic [7:0]  rx_data_i = 0, tx_data_o, s_axi_awaddr = 0, s_axi_araddr = 0, rsp[$];
    logic [31:0] band_mask_o, elev_limit_o, signal_limit_o, dilution_limit_o, cable_delay_o;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid;
    int          bad_count = 0, n_tests = 0;
    rcc_top dut_u (.*);
    rcc_store_model sm_u (.clk_i(clk_i), .store_req_i(store_req_o), .ok_sel_i(ok_sel),
        .delay_i(4'h3), .store_done_o(store_done_i), .store_ok_o(store_ok_i));
    initial forever #2 clk_i = ~clk_i;
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(logic [7:0] sub, logic [7:0] body[$], logic bad);
        logic [7:0] p[$];
        logic [7:0] c;
        p = {FRM_START, FRM_PID, sub, 8'h00, 8'(body.size() + 1), body};
        c = 8'h00;
        foreach (p[i]) if (i > 0) c ^= p[i];
        p = {p, c ^ {7'h0, bad}, FRM_END1, FRM_END2};
        foreach (p[i]) begin
            rx_valid_i <= 1'h1;
            rx_data_i  <= p[i];
            do @(posedge clk_i); while (rx_ready_o !== 1'h1);
        end
        rx_valid_i <= 1'h0;
    endtask
    task automatic frame(logic [7:0] sub, int n);
        logic [7:0] c;
        rsp = {};
        while (rsp.size() < n) begin
            @(posedge clk_i);
            if (tx_valid_o === 1'h1) rsp.push_back(tx_data_o);
        end
        c = 8'h00;
        for (int i = 1; i < n - 3; i++) c ^= rsp[i];
        cmp("start", FRM_START, rsp[0]);
        cmp("pid", FRM_PID, rsp[1]);
        cmp("sub", sub, rsp[2]);
        cmp("len", 32'(n - 7), {rsp[3], rsp[4]});
        cmp("mode", MODE_RESP, rsp[5]);
        cmp("cks", c, rsp[n-3]);
        cmp("end", {FRM_END1, FRM_END2}, {rsp[n-2], rsp[n-1]});
    endtask
    task automatic axi_wr(logic [7:0] a, output logic [1:0] rs);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do @(posedge clk_i); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid  <= 1'h0;
        do @(posedge clk_i); while (s_axi_bvalid !== 1'h1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_rd(logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do @(posedge clk_i); while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_arvalid <= 1'h0;
        s_axi_rready  <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic t_query();
        send(SUB_RXCFG, {MODE_QUERY}, 1'h0);
        frame(SUB_RXCFG, 35);
        cmp("rsp mask", RST_MASK, {rsp[6], rsp[7], rsp[8], rsp[9]});
        cmp("rsp dil", RST_DIL, {rsp[18], rsp[19], rsp[20], rsp[21]});
    endtask
    task automatic t_set();
        // Signal absent, dilution 11.0 out of range
        send(SUB_RXCFG, {MODE_SET, 8'h00, 8'h00, 8'hff, 8'hff, 8'h41, 8'hf0, 8'h00, 8'h00,
            8'hff, 8'hff, 8'hff, 8'hff, 8'h41, 8'h30, 8'h00, 8'h00, RST_AJ, RST_FIX,
            8'h01, 8'h02, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 1'h0);
        frame(SUB_RXCFG, 35);
        cmp("echo mask", 32'h0000_5135, {rsp[6], rsp[7], rsp[8], rsp[9]});
        overdet_mode_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        cmp("bands", 32'h0000_ffff & MASK_SUPP, band_mask_o);
        cmp("elev", 32'h41f0_0000, elev_limit_o);
        cmp("signal", RST_SIG, signal_limit_o);
        cmp("dil", RST_DIL, dilution_limit_o);
        cmp("cable", 32'h0102_0304, cable_delay_o);
        overdet_mode_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        cmp("elev off", 32'h0000_0000, elev_limit_o);
    endtask
    task automatic t_bad();
        logic [7:0] b[$];
        logic       seen;
        b = {MODE_SET};
        repeat (26) b.push_back(8'h00);
        seen = 1'h0;
        send(SUB_RXCFG, b, 1'h1);
        repeat (20) @(posedge clk_i) seen |= tx_valid_o;
        cmp("silent", 1'h0, seen);
        cmp("kept", 32'h0000_5135, band_mask_o);
    endtask
    task automatic t_save();
        for (int k = 0; k < 2; k++) begin
            ok_sel <= k[0];
            send(SUB_STORE, {MODE_SET, SAVE_DO, 8'h00, 8'h00, 8'h00, 8'h00}, 1'h0);
            frame(SUB_STORE, 14);
            cmp("status", 32'(k), rsp[6]);
        end
    endtask
    task automatic t_regs();
        axi_rd(A_MASK, d, r);
        cmp("mask reg", 32'h0000_5135, d);
        axi_rd(8'h2c, d, r);
        cmp("unmapped", RESP_SLVERR, r);
        axi_wr(A_STAT, r);
        cmp("ro write", RESP_SLVERR, r);
    endtask
    task automatic print_verdict();
        $display("Checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #40000;
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'h1;
        t_query();
        t_set();
        t_bad();
        t_save();
        t_regs();
        print_verdict();
    end
endmodule
